/* mac_phy_mgmt_flow_regs.v */
// PHY management access, data and pause flow control registers.
// Assumes an Avalon-MM master, a request/acknowledge PHY register port,
// and a transmit byte path that yields to the pause frame when asked.
//
// Design decision made here: the Avalon-MM interface to the registers.
`include "mac_mgmt_defs.vh"

module mac_phy_mgmt_flow_regs #(
  parameter QUANTUM_10 = `QUANTUM_10_CYC
) (
  input  wire        ref_clk_in,
  input  wire        rst_in,
  // Avalon-MM slave, byte address.
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [3:0]  avs_byteenable,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Integrated PHY register port.
  output reg         phy_req_out,
  output reg         phy_we_out,
  output reg  [4:0]  phy_addr_out,
  output reg  [4:0]  phy_reg_index_out,
  output reg  [15:0] phy_wdata_out,
  input  wire        phy_ack_in,
  input  wire [15:0] phy_rdata_in,
  // MAC operating state.
  input  wire        full_duplex_in,
  input  wire        speed_100_in,
  input  wire        tx_enable_in,
  input  wire [47:0] mac_addr_in,
  // Flow control requests from the automatic flow logic.
  input  wire        pause_req_in,
  input  wire        backpressure_req_in,
  output reg         backpressure_out,
  // Pause frame byte stream towards the transmitter.
  output wire        pause_tx_valid_out,
  output wire [7:0]  pause_tx_data_out,
  output wire        pause_tx_last_out,
  input  wire        pause_tx_ready_in,
  // Receive side: pause frames recognised by the receive parser.
  input  wire        rx_pause_valid_in,
  input  wire [15:0] rx_pause_time_in,
  output reg         rx_pause_filtered_out,
  output reg         rx_forward_out,
  output wire        tx_halt_out
);

  localparam QW = 13;
  localparam [31:0]  ACC_RST  = `RST_PHY_MGMT_ACCESS;
  localparam [31:0]  DATA_RST = `RST_PHY_MGMT_DATA;
  localparam [31:0]  FLOW_RST = `RST_PAUSE_FLOW_CONTROL;
  localparam integer Q100     = `QUANTUM_100_CYC;

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  reg  [4:0]  phy_addr_q;
  reg  [4:0]  reg_index_q;
  reg         write_sel_q;
  reg         mgmt_busy_q;
  reg  [15:0] mgmt_data_q;
  reg  [15:0] pause_time_q;
  reg         pass_ctl_q;
  reg         fc_enable_q;
  reg         pause_pending_q;
  reg         ack_q;

  wire        access;
  wire        accept;
  wire [5:0]  idx;
  wire [31:0] be_mask;
  wire [31:0] acc_rd;
  wire [31:0] flow_rd;
  wire [31:0] acc_wr;
  wire [31:0] data_wr;
  wire [31:0] flow_wr;
  wire        wr_acc;
  wire        wr_data;
  wire        wr_flow;
  wire        gen_active;
  wire        gen_start;
  wire        flow_busy;
  wire        fd_rx_on;
  wire        pause_load;
  wire [QW-1:0] quantum;

  // ****************************************************************
  // Bus slave: one wait state, then the answer at the next edge.
  // ****************************************************************

  // Every access waits exactly one cycle so read data can be
  // registered; this costs latency but keeps the read mux off the
  // output path.
  assign access          = avs_read | avs_write;
  assign avs_waitrequest = access & ~ack_q;
  assign accept          = access & ack_q;
  assign idx             = avs_address[7:2];

  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  assign wr_acc  = avs_write & accept & (idx == `IDX_PHY_MGMT_ACCESS);
  assign wr_data = avs_write & accept & (idx == `IDX_PHY_MGMT_DATA);
  assign wr_flow = avs_write & accept & (idx == `IDX_PAUSE_FLOW_CONTROL);

  // Merge enabled byte lanes into the current value; reserved bits drop.
  assign acc_wr  = ((avs_writedata & be_mask) | (acc_rd & ~be_mask))
                   & `ACC_WRITABLE_MASK;
  assign data_wr = ((avs_writedata & be_mask)
                   | ({16'h0000, mgmt_data_q} & ~be_mask))
                   & `DATA_MASK;
  assign flow_wr = ((avs_writedata & be_mask) | (flow_rd & ~be_mask))
                   & `FLOW_WRITABLE_MASK;

  // Readback images; reserved positions are tied to zero.
  assign acc_rd = {16'h0000, phy_addr_q, reg_index_q, 4'h0,
                   write_sel_q, mgmt_busy_q};
  assign flow_rd = {pause_time_q, 13'h0000, pass_ctl_q, fc_enable_q,
                    flow_busy};

  // Wait-state toggle: high in the cycle the answer is given.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in)
      ack_q <= 1'b0;
    else
      ack_q <= access & ~ack_q;
  end

  // Read data are sampled during the wait cycle and stand at the edge
  // where waitrequest is low; unmapped indexes read as zero.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_q) begin
      case (idx)
        `IDX_PHY_MGMT_ACCESS:    avs_readdata <= acc_rd;
        `IDX_PHY_MGMT_DATA:      avs_readdata <= {16'h0000,
                                                  mgmt_data_q};
        `IDX_PAUSE_FLOW_CONTROL: avs_readdata <= flow_rd;
        default:                 avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // PHY management access.
  // ****************************************************************

  // Fields are stored as written; software is expected to keep the PHY
  // address at the integrated PHY's value, and the field is passed on
  // unchanged so a wrong value is visible on the port. A write while a
  // cycle runs is dropped so the live request is never disturbed.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phy_addr_q  <= ACC_RST[`ACC_PHY_ADDR_HI:`ACC_PHY_ADDR_LO];
      reg_index_q <= 5'h00;
      write_sel_q <= 1'b0;
      mgmt_busy_q <= 1'b0;
    end else if (wr_acc && !mgmt_busy_q) begin
      phy_addr_q  <= acc_wr[`ACC_PHY_ADDR_HI:`ACC_PHY_ADDR_LO];
      reg_index_q <= acc_wr[`ACC_REG_INDEX_HI:`ACC_REG_INDEX_LO];
      write_sel_q <= acc_wr[`ACC_WRITE_SELECT];
      mgmt_busy_q <= acc_wr[`ACC_BUSY];
    end else if (mgmt_busy_q && phy_req_out && phy_ack_in) begin
      mgmt_busy_q <= 1'b0;
    end
  end

  // Request to the PHY: raised the cycle after busy is set and held
  // until acknowledged, carrying index, direction and write data.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phy_req_out       <= 1'b0;
      phy_we_out        <= 1'b0;
      phy_addr_out      <= 5'h00;
      phy_reg_index_out <= 5'h00;
      phy_wdata_out     <= 16'h0000;
    end else if (phy_req_out) begin
      if (phy_ack_in)
        phy_req_out <= 1'b0;
    end else if (mgmt_busy_q) begin
      phy_req_out       <= 1'b1;
      phy_we_out        <= write_sel_q;
      phy_addr_out      <= phy_addr_q;
      phy_reg_index_out <= reg_index_q;
      phy_wdata_out     <= mgmt_data_q;
    end
  end

  // Data register: loaded by software, or by the PHY at the end of a
  // read. The read result then stays until software touches it again.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mgmt_data_q <= DATA_RST[15:0];
    end else if (mgmt_busy_q && phy_req_out && phy_ack_in
                 && !write_sel_q) begin
      mgmt_data_q <= phy_rdata_in;
    end else if (wr_data && !mgmt_busy_q) begin
      mgmt_data_q <= data_wr[15:0];
    end
  end

  // ****************************************************************
  // Flow control register.
  // ****************************************************************

  // The busy bit is never stored from the bus, so a one written there
  // has no effect; a write while busy is dropped to protect the frame
  // that is already on its way.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pause_time_q <= FLOW_RST[`FLOW_TIME_HI:`FLOW_TIME_LO];
      pass_ctl_q   <= 1'b0;
      fc_enable_q  <= 1'b0;
    end else if (wr_flow && !flow_busy) begin
      pause_time_q <= flow_wr[`FLOW_TIME_HI:`FLOW_TIME_LO];
      pass_ctl_q   <= flow_wr[`FLOW_PASS_CTL];
      fc_enable_q  <= flow_wr[`FLOW_ENABLE];
    end
  end

  // ****************************************************************
  // Pause transmission and back pressure.
  // ****************************************************************

  // A request in full duplex with transmit enabled is remembered until the generator takes it, or until either drops;
  // a new request arriving while one is taken is kept, not lost.
  assign gen_start = pause_pending_q & ~gen_active & tx_enable_in
                     & full_duplex_in;

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in)
      pause_pending_q <= 1'b0;
    else if (pause_req_in && full_duplex_in && tx_enable_in)
      pause_pending_q <= 1'b1;
    else if (gen_start || !full_duplex_in || !tx_enable_in)
      pause_pending_q <= 1'b0;
  end

  // Back pressure only in half duplex, only with the enable bit set and
  // only while the transmitter may drive the medium.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in)
      backpressure_out <= 1'b0;
    else
      backpressure_out <= backpressure_req_in & fc_enable_q
                          & ~full_duplex_in & tx_enable_in;
  end

  // Busy covers the wait for the generator and the whole frame, or the
  // back pressure time in half duplex.
  assign flow_busy = pause_pending_q | gen_active
                     | backpressure_out;

  pause_frame_gen u_gen (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .start_in      (gen_start),
    .src_addr_in   (mac_addr_in),
    .pause_time_in (pause_time_q),
    .tx_ready_in   (pause_tx_ready_in),
    .tx_valid_out  (pause_tx_valid_out),
    .tx_data_out   (pause_tx_data_out),
    .tx_last_out   (pause_tx_last_out),
    .active_out    (gen_active)
  );

  // ****************************************************************
  // Receive side.
  // ****************************************************************

  // Pause decoding is acted on only with the enable bit set in full
  // duplex; the quantum follows the line rate.
  assign fd_rx_on   = fc_enable_q & full_duplex_in;
  assign pause_load = rx_pause_valid_in & fd_rx_on;
  assign quantum    = speed_100_in ? Q100[QW-1:0]
                                   : QUANTUM_10[QW-1:0];

  pause_timer #(
    .QW (QW)
  ) u_timer (
    .ref_clk_in     (ref_clk_in),
    .rst_in         (rst_in),
    .load_in        (pause_load),
    .quanta_in      (rx_pause_time_in),
    .quantum_cyc_in (quantum),
    .halt_out       (tx_halt_out)
  );

  // Status for the frame just seen; frames are always forwarded.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_pause_filtered_out <= 1'b0;
      rx_forward_out        <= 1'b0;
    end else begin
      rx_pause_filtered_out <= rx_pause_valid_in & pass_ctl_q;
      rx_forward_out        <= rx_pause_valid_in;
    end
  end

endmodule // mac_phy_mgmt_flow_regs

/* mac_mgmt_defs.vh */
// Constants for the PHY management and pause flow control register slice.
// Assumes a 100 MHz clock and a word-indexed register map on a byte bus.
`ifndef MAC_MGMT_DEFS_VH
`define MAC_MGMT_DEFS_VH

// ****************************************************************
// Register indexes; the byte address is four times the index.
// ****************************************************************
`define IDX_PHY_MGMT_ACCESS    6'h06
`define IDX_PHY_MGMT_DATA      6'h07
`define IDX_PAUSE_FLOW_CONTROL 6'h08
`define RST_PHY_MGMT_ACCESS    32'h00000000
`define RST_PHY_MGMT_DATA      32'h00000000
`define RST_PAUSE_FLOW_CONTROL 32'h00000000

// ****************************************************************
// Field positions.
// ****************************************************************
`define ACC_PHY_ADDR_HI   15
`define ACC_PHY_ADDR_LO   11
`define ACC_REG_INDEX_HI  10
`define ACC_REG_INDEX_LO  6
`define ACC_WRITE_SELECT  1
`define ACC_BUSY          0
`define ACC_WRITABLE_MASK 32'h0000ffc3
`define DATA_MASK         32'h0000ffff
`define FLOW_TIME_HI      31
`define FLOW_TIME_LO      16
`define FLOW_PASS_CTL     2
`define FLOW_ENABLE       1
`define FLOW_BUSY         0
`define FLOW_WRITABLE_MASK 32'hffff0006
`define PHY_ADDR_INTERNAL 5'h01

// ****************************************************************
// Pause frame fields and timing.
// ****************************************************************
`define PAUSE_DEST_ADDR   48'h0180c2000001
`define PAUSE_ETH_TYPE    16'h8808
`define PAUSE_OPCODE      16'h0001
`define PAUSE_FRAME_BYTES 6'h3c
`define CLK_PERIOD_NS     10
`define SLOT_BIT_TIMES    512
`define BIT_TIME_100_NS   10
`define BIT_TIME_10_NS    100
`define QUANTUM_100_CYC ((`SLOT_BIT_TIMES * `BIT_TIME_100_NS) / `CLK_PERIOD_NS)
`define QUANTUM_10_CYC ((`SLOT_BIT_TIMES * `BIT_TIME_10_NS) / `CLK_PERIOD_NS)

`endif

/* pause_frame_gen.v */
// Streams one pause control frame, 60 bytes without CRC, byte by byte.
// Assumes the transmit path appends the CRC and honours tx_ready_in.
`include "mac_mgmt_defs.vh"

module pause_frame_gen (
  input  wire        ref_clk_in,
  input  wire        rst_in,
  input  wire        start_in,
  input  wire [47:0] src_addr_in,
  input  wire [15:0] pause_time_in,
  input  wire        tx_ready_in,
  output wire        tx_valid_out,
  output reg  [7:0]  tx_data_out,
  output wire        tx_last_out,
  output wire        active_out
);

  reg        active_q;
  reg  [5:0] idx_q;
  reg  [7:0] byte_d;
  wire       take;
  wire [5:0] nxt_idx;

  localparam [79:0] FIXED_HDR = {`PAUSE_DEST_ADDR, `PAUSE_ETH_TYPE,
                                 `PAUSE_OPCODE};

  assign take         = active_q & tx_ready_in;
  assign nxt_idx      = (start_in && !active_q) ? 6'h00
                        : (take ? idx_q + 6'h01 : idx_q);
  assign tx_valid_out = active_q;
  assign active_out   = active_q;
  assign tx_last_out  = active_q & (idx_q == (`PAUSE_FRAME_BYTES - 6'h01));

  // Fixed fields of the MAC control frame format, plus source address and pause time; the rest is pad.
  always @* begin
    byte_d = 8'h00;
    case (nxt_idx)
      6'h00: byte_d = FIXED_HDR[79:72];
      6'h01: byte_d = FIXED_HDR[71:64];
      6'h02: byte_d = FIXED_HDR[63:56];
      6'h03: byte_d = FIXED_HDR[55:48];
      6'h04: byte_d = FIXED_HDR[47:40];
      6'h05: byte_d = FIXED_HDR[39:32];
      6'h06: byte_d = src_addr_in[47:40];
      6'h07: byte_d = src_addr_in[39:32];
      6'h08: byte_d = src_addr_in[31:24];
      6'h09: byte_d = src_addr_in[23:16];
      6'h0a: byte_d = src_addr_in[15:8];
      6'h0b: byte_d = src_addr_in[7:0];
      6'h0c: byte_d = FIXED_HDR[31:24];
      6'h0d: byte_d = FIXED_HDR[23:16];
      6'h0e: byte_d = FIXED_HDR[15:8];
      6'h0f: byte_d = FIXED_HDR[7:0];
      6'h10: byte_d = pause_time_in[15:8];
      6'h11: byte_d = pause_time_in[7:0];
      default: byte_d = 8'h00;
    endcase
  end

  // The data register is reloaded one byte ahead as each byte is taken.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      active_q    <= 1'b0;
      idx_q       <= 6'h00;
      tx_data_out <= 8'h00;
    end else begin
      tx_data_out <= byte_d;
      if (start_in && !active_q) begin
        active_q <= 1'b1;
        idx_q    <= 6'h00;
      end else if (take) begin
        if (tx_last_out)
          active_q <= 1'b0;
        idx_q <= idx_q + 6'h01;
      end
    end
  end

endmodule // pause_frame_gen

/* pause_timer.v */
// Counts a received pause time in slot-time quanta and holds the halt.
// Assumes the quantum length is given in clock cycles by the caller.
`include "mac_mgmt_defs.vh"

module pause_timer #(
  parameter QW = 13
) (
  input  wire          ref_clk_in,
  input  wire          rst_in,
  input  wire          load_in,
  input  wire [15:0]   quanta_in,
  input  wire [QW-1:0] quantum_cyc_in,
  output wire          halt_out
);

  reg [15:0]   left_q;
  reg [QW-1:0] cyc_q;

  assign halt_out = (left_q != 16'h0000);

  // A new pause frame restarts the count; a zero time ends the halt.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      left_q <= 16'h0000;
      cyc_q  <= {QW{1'b0}};
    end else if (load_in) begin
      left_q <= quanta_in;
      cyc_q  <= quantum_cyc_in - {{(QW-1){1'b0}}, 1'b1};
    end else if (halt_out) begin
      if (cyc_q == {QW{1'b0}}) begin
        left_q <= left_q - 16'h0001;
        cyc_q  <= quantum_cyc_in - {{(QW-1){1'b0}}, 1'b1};
      end else begin
        cyc_q <= cyc_q - {{(QW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // pause_timer

/* phy_mgmt_model.sv */
// Behavioural register file of the integrated PHY on the request port.
// Assumes the request is held until acknowledged, one access at a time.
module phy_mgmt_model (
  input  logic        ref_clk_in,
  input  logic        rst_in,
  input  logic [3:0]  dly_in,
  input  logic        req_in,
  input  logic        we_in,
  input  logic [4:0]  addr_in,
  input  logic [4:0]  idx_in,
  input  logic [15:0] wdata_in,
  output logic        ack_out,
  output logic [15:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [32];
  logic [3:0]  cnt_q;

  // Answers after dly_in idle cycles. Read data toggle outside the ack
  // cycle, so a design that samples late never sees a stale match.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
      rdata_out <= 16'h0000;
      cnt_q <= 4'h0;
    end else begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (req_in && !ack_out) begin
        if (cnt_q >= dly_in) begin
          ack_out <= 1'b1;
          cnt_q <= 4'h0;
          if (addr_in == 5'h01 && we_in) mem[idx_in] <= wdata_in;
          if (addr_in == 5'h01 && !we_in) rdata_out <= mem[idx_in];
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule // phy_mgmt_model

/* mac_phy_mgmt_flow_regs_sva.sv */
// Port checker for the management and flow control register slice.
// Assumes one clock domain and the asynchronous active high reset.
module mac_phy_mgmt_flow_regs_chk (
  input logic        ref_clk_in,
  input logic        rst_in,
  input logic        avs_read,
  input logic        avs_write,
  input logic        avs_waitrequest,
  input logic        phy_req_out,
  input logic        phy_ack_in,
  input logic [4:0]  phy_reg_index_out,
  input logic [15:0] phy_wdata_out,
  input logic        tx_enable_in,
  input logic        full_duplex_in,
  input logic        backpressure_out,
  input logic        pause_tx_valid_out,
  input logic [7:0]  pause_tx_data_out,
  input logic        pause_tx_last_out,
  input logic        pause_tx_ready_in,
  input logic        rx_pause_valid_in,
  input logic        rx_pause_filtered_out,
  input logic        rx_forward_out,
  input logic        tx_halt_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic [5:0] cnt_q;

  // Counts accepted frame bytes; the last flag must land on byte 60.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) cnt_q <= 6'h00;
    else if (pause_tx_valid_out && pause_tx_ready_in)
      cnt_q <= pause_tx_last_out ? 6'h00 : cnt_q + 6'h01;
  end

  // ****
  // Assertions
  // ****
  a_wait_single: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("more than one wait state");
  a_req_holds: assert property (phy_req_out && !phy_ack_in |=> phy_req_out
    && $stable(phy_reg_index_out) && $stable(phy_wdata_out))
    else $error("phy request dropped or changed early");
  a_req_drops: assert property (phy_req_out && phy_ack_in |=> !phy_req_out)
    else $error("phy request kept after ack");
  a_fwd_pulse: assert property (1'b1 |=> rx_forward_out == $past(rx_pause_valid_in))
    else $error("forward pulse wrong");
  a_filt_cause: assert property (rx_pause_filtered_out |-> $past(rx_pause_valid_in))
    else $error("filtered flag without pause frame");
  a_halt_load: assert property ($rose(tx_halt_out) |-> $past(rx_pause_valid_in))
    else $error("halt without received pause");
  a_bp_gated: assert property (!$past(tx_enable_in) || $past(full_duplex_in)
    |-> !backpressure_out) else $error("back pressure not allowed");
  a_frame_len: assert property (pause_tx_valid_out && pause_tx_ready_in
    |-> pause_tx_last_out == (cnt_q == 6'd59)) else $error("frame length");
  a_byte_hold: assert property (pause_tx_valid_out && !pause_tx_ready_in
    |=> pause_tx_valid_out && $stable(pause_tx_data_out))
    else $error("frame byte not held");
  a_first_byte: assert property ($rose(pause_tx_valid_out)
    |-> pause_tx_data_out == 8'h01) else $error("first frame byte");
  c_frame: cover property (pause_tx_last_out && pause_tx_ready_in);
  c_ack: cover property (phy_req_out && phy_ack_in);
  c_halt: cover property ($fell(tx_halt_out));
endmodule // mac_phy_mgmt_flow_regs_chk

/* mac_phy_mgmt_flow_regs_tb.sv */
// Self-checking bench for the management and flow control registers.
// Assumes the PHY model file and the checker file are compiled first.
module mac_phy_mgmt_flow_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q10 = 8;
  logic        ref_clk_in, rst_in, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address, pause_tx_data_out;
  logic [3:0]  avs_byteenable, phy_dly;
  logic [31:0] avs_writedata, avs_readdata;
  logic        phy_req_out, phy_we_out, phy_ack_in, full_duplex_in;
  logic [4:0]  phy_addr_out, phy_reg_index_out;
  logic [15:0] phy_wdata_out, phy_rdata_in, rx_pause_time_in;
  logic        speed_100_in, tx_enable_in, pause_req_in, backpressure_out;
  logic [47:0] mac_addr_in;
  logic        backpressure_req_in, pause_tx_valid_out, pause_tx_last_out;
  logic        pause_tx_ready_in, rx_pause_valid_in, rx_pause_filtered_out;
  logic        rx_forward_out, tx_halt_out;
  int          err_total, samples_checked, cyc;

  mac_phy_mgmt_flow_regs #(.QUANTUM_10(Q10)) uut (.ref_clk_in, .rst_in,
    .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .phy_req_out, .phy_we_out,
    .phy_addr_out, .phy_reg_index_out, .phy_wdata_out, .phy_ack_in,
    .phy_rdata_in, .full_duplex_in, .speed_100_in, .tx_enable_in,
    .mac_addr_in, .pause_req_in, .backpressure_req_in, .backpressure_out,
    .pause_tx_valid_out, .pause_tx_data_out, .pause_tx_last_out,
    .pause_tx_ready_in, .rx_pause_valid_in, .rx_pause_time_in,
    .rx_pause_filtered_out, .rx_forward_out, .tx_halt_out);
  phy_mgmt_model phy (.ref_clk_in, .rst_in, .dly_in(phy_dly),
    .req_in(phy_req_out), .we_in(phy_we_out), .addr_in(phy_addr_out),
    .idx_in(phy_reg_index_out), .wdata_in(phy_wdata_out),
    .ack_out(phy_ack_in), .rdata_out(phy_rdata_in));

  // ****
  // Shared tasks
  // ****
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // A hang is cut short here; the run needs well under 2000 cycles.
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The request stands until waitrequest is sampled low at a rising
  // edge; read data are taken there, then one idle edge is let pass.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge ref_clk_in); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task automatic poll(input logic [7:0] a);
    logic [31:0] q;
    do bus(1'b0, a, 32'h0, q); while (q[0] !== 1'b0);
  endtask

  task automatic rxp(input logic [15:0] t);
    rx_pause_time_in <= t;
    rx_pause_valid_in <= 1'b1;
    @(posedge ref_clk_in);
    rx_pause_valid_in <= 1'b0;
    @(negedge ref_clk_in);
  endtask

  function automatic logic [7:0] pbyte(input int i);
    logic [143:0] h;
    h = {48'h0180c2000001, mac_addr_in, 32'h88080001, 16'h1234};
    pbyte = (i < 18) ? h[143 - 8 * i -: 8] : 8'h00;
  endfunction

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    logic [31:0] q;
    bus(1'b1, 8'h24, 32'hffffffff, q);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'h18 + 8'(4 * i), 32'h0, q);
      chk(q, 32'h0);
    end
  endtask

  // A slow write to index 27, then a prompt read of index 5.
  task automatic t_phy;
    logic [31:0] q;
    phy_dly <= 4'h6;
    bus(1'b1, 8'h1c, 32'hbeefabcd, q);
    bus(1'b0, 8'h1c, 32'h0, q);
    chk(q, 32'h0000abcd);
    bus(1'b1, 8'h18, 32'hffff0ec3, q);
    bus(1'b0, 8'h18, 32'h0, q);
    chk(q, 32'h00000ec3);
    poll(8'h18);
    chk({16'h0, phy.mem[27]}, 32'h0000abcd);
    phy_dly <= 4'h0;
    bus(1'b1, 8'h18, 32'h00000941, q);
    poll(8'h18);
    bus(1'b0, 8'h1c, 32'h0, q);
    chk(q, 32'h00005a3c);
    bus(1'b0, 8'h1c, 32'h0, q);
    chk(q, 32'h00005a3c);
  endtask

  // The transmitter stalls every other cycle while the frame streams.
  task automatic t_pause;
    logic [31:0] q;
    int n;
    pause_tx_ready_in <= 1'b0;
    bus(1'b1, 8'h20, 32'hfffffffe, q);
    bus(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'hffff0006);
    bus(1'b1, 8'h20, 32'h12340002, q);
    pause_req_in <= 1'b1;
    @(posedge ref_clk_in);
    pause_req_in <= 1'b0;
    bus(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h12340003);
    n = 0;
    while (n < 60) begin
      @(negedge ref_clk_in);
      if (pause_tx_valid_out === 1'b1 && pause_tx_ready_in === 1'b1) begin
        chk(pause_tx_data_out, pbyte(n));
        n++;
      end
      @(posedge ref_clk_in);
      pause_tx_ready_in <= !pause_tx_ready_in;
    end
    bus(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h12340002);
  endtask

  task automatic t_half;
    logic [31:0] q;
    full_duplex_in <= 1'b0;
    backpressure_req_in <= 1'b1;
    repeat (3) @(negedge ref_clk_in);
    chk(backpressure_out, 1'b1);
    @(posedge ref_clk_in);
    bus(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h12340003);
    tx_enable_in <= 1'b0;
    repeat (3) @(negedge ref_clk_in);
    chk(backpressure_out, 1'b0);
    @(posedge ref_clk_in);
    backpressure_req_in <= 1'b0;
    full_duplex_in <= 1'b1;
    pause_req_in <= 1'b1;
    @(posedge ref_clk_in);
    pause_req_in <= 1'b0;
    repeat (4) @(negedge ref_clk_in);
    chk(pause_tx_valid_out, 1'b0);
    @(posedge ref_clk_in);
    tx_enable_in <= 1'b1;
    @(posedge ref_clk_in);
  endtask

  task automatic t_rx;
    logic [31:0] q;
    int n;
    poll(8'h20);
    bus(1'b1, 8'h20, 32'h00000006, q);
    rxp(16'h0002);
    chk(rx_pause_filtered_out, 1'b1);
    chk(rx_forward_out, 1'b1);
    n = 0;
    repeat (30) begin
      n += int'(tx_halt_out === 1'b1);
      @(negedge ref_clk_in);
    end
    chk(n, 2 * Q10);
    @(posedge ref_clk_in);
    bus(1'b1, 8'h20, 32'h00000004, q);
    rxp(16'h0002);
    chk(rx_pause_filtered_out, 1'b1);
    @(negedge ref_clk_in);
    chk(tx_halt_out, 1'b0);
    @(posedge ref_clk_in);
    bus(1'b1, 8'h20, 32'h0, q);
    rxp(16'h0002);
    chk(rx_pause_filtered_out, 1'b0);
    chk(rx_forward_out, 1'b1);
  endtask

  task complete_run;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Main sequence: reset for six cycles, then each scenario in turn.
  initial begin
    rst_in = 1'b1;
    {avs_read, avs_write, pause_req_in, backpressure_req_in} = 4'h0;
    {pause_tx_ready_in, rx_pause_valid_in, speed_100_in} = 3'h0;
    {full_duplex_in, tx_enable_in} = 2'h3;
    avs_address = 8'h00;
    avs_byteenable = 4'hf;
    avs_writedata = 32'h0;
    phy_dly = 4'h0;
    mac_addr_in = 48'h02a1b2c3d4e5;
    rx_pause_time_in = 16'h0000;
    phy.mem[5] = 16'h5a3c;
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    t_reset;
    t_phy;
    t_pause;
    t_half;
    t_rx;
    complete_run;
  end
endmodule // mac_phy_mgmt_flow_regs_tb

bind mac_phy_mgmt_flow_regs mac_phy_mgmt_flow_regs_chk chk (.ref_clk_in,
  .rst_in, .avs_read, .avs_write, .avs_waitrequest, .phy_req_out,
  .phy_ack_in, .phy_reg_index_out, .phy_wdata_out, .tx_enable_in,
  .full_duplex_in, .backpressure_out, .pause_tx_valid_out,
  .pause_tx_data_out, .pause_tx_last_out, .pause_tx_ready_in,
  .rx_pause_valid_in, .rx_pause_filtered_out, .rx_forward_out,
  .tx_halt_out);
